// File: dbr_map.vh
`ifndef DBR_MAP_VH
`define DBR_MAP_VH
// bus widths
`define DBR_BA_W      3
`define DBR_ADDR_W    15
`define DBR_DQ_W      16
`define DBR_NBANK     8
`define DBR_TIME_W    8
`define DBR_LAT_W     4
`define DBR_DESC_W    38
`define DBR_FIFO_D    16
`define DBR_FIFO_AW   4
// address bit positions
`define DBR_A_AUTOPRE 10
`define DBR_A_BLSEL   12
`define DBR_A_NIBBLE  2
`define DBR_COL_HI    9
`define DBR_COL_LO    3
// mode register three: enable bit and selector field
`define DBR_MR3_BA    3'h3
`define DBR_MR3_EN    2
`define DBR_MR3_SELHI 1
`define DBR_SEL_PAT   2'h0
// predefined pattern, beat 0 in the lsb
`define DBR_PATTERN   8'hAA
// beats per burst
`define DBR_BEATS_BL8 4'h8
`define DBR_BEATS_BC4 4'h4
`define DBR_NIB_BASE  3'h4
// precharge period in link clock cycles
`define DBR_PRE_CK    5'h0B
`define DBR_PRE_W     5
`endif

// File: dbr_core.v
`timescale 1ns/100ps
`include "dbr_map.vh"

module dbr_fifo #(
	parameter W  = 38,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire         clk_sys,  // system clock
	input  wire         nrst,     // sync reset, active low
	input  wire [W-1:0] in_data,  // fill data
	input  wire         in_valid, // fill request
	output wire         in_ready, // not full
	output wire [W-1:0] out_data, // head entry
	output wire         out_valid,// not empty
	input  wire         out_ready // pop head
);
	reg [W-1:0] mem [0:D-1];
	reg [AW:0]  wr_ptr_reg;
	reg [AW:0]  rd_ptr_reg;
	wire        full;
	wire        empty;
	assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
	                   (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty     = (wr_ptr_reg == rd_ptr_reg);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr_reg[AW-1:0]];
	always @(posedge clk_sys) begin
		if (in_valid && !full)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end
	always @(posedge clk_sys) begin
		if (!nrst) begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (out_ready && !empty)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule

// How it works
// [RQ1] pattern mode, selector 00: eight-beat read returns 0,1,0,1,0,1,0,1 in order
// [RQ2] chopped pattern read: address bit 2 low gives beats 0-3, high gives 4-7
// [RQ3] beat position 0 is the pattern lsb, position 7 its msb
// [RQ4] activate opens the row on the address inputs in the selected bank
// [RQ5] an open row stays open until a precharge reaches its bank
// [RQ6] controller precharges before activating another row in the same bank
// [RQ7] precharge closes one addressed bank or all banks, per auto-precharge bit
// [RQ8] controller waits the precharge period before activating the bank again
// [RQ9] controller may access another bank while one auto-precharges
// [RQ10] a precharged bank is idle and must be activated before access
// [RQ11] precharge to idle or precharging bank accepted; timer restarts from latest
// [RQ12] selector bit low gives four-beat chopped burst, high gives eight beats
// [RQ13] selector bit sets burst length only, never part of the column
// [RQ14] burst selection works with and without auto-precharge on reads
// [RQ15] data starts additive plus cas latency cycles after the read
// [RQ16] pattern mode off: reads come from the array
// [RQ17] controller keeps the delay-locked loop locked before pattern reads
// [RQ18] selector codes 01, 10, 11 are reserved and return undefined data
// [RQ19] flag access to an idle bank and activate to an open bank; idle access in pattern mode is not flagged
module dbr_core (
	input  wire                    clk_sys,        // 200 MHz system clock
	input  wire                    nrst,           // sync reset, active low
	input  wire                    ck,             // link command clock pin
	input  wire                    cs_n,           // chip select, active low
	input  wire                    ras_n,          // row strobe, active low
	input  wire                    cas_n,          // column strobe, active low
	input  wire                    we_n,           // write enable, active low
	input  wire [`DBR_BA_W-1:0]    bank_select,    // bank select inputs
	input  wire [`DBR_ADDR_W-1:0]  addr,           // address inputs
	input  wire [`DBR_LAT_W-1:0]   additive_latency, // additive latency in ck
	input  wire [`DBR_LAT_W-1:0]   cas_latency,    // cas latency in ck
	input  wire [`DBR_DQ_W-1:0]    array_data,     // array word for array_* address
	output reg  [`DBR_BA_W-1:0]    array_bank_reg, // array read bank
	output reg  [`DBR_ADDR_W-1:0]  array_row_reg,  // array read row
	output reg  [`DBR_COL_HI:0]    array_col_reg,  // array read column
	output reg  [`DBR_DQ_W-1:0]    dq_out_reg,     // read beat data
	output reg                     dq_valid_reg,   // read beat strobe, pulse
	output reg  [2:0]              beat_pos_reg,   // burst order position of beat
	output reg  [`DBR_NBANK-1:0]   bank_open_reg,  // open row per bank
	output reg                     pattern_en_reg, // pattern mode enabled
	output reg                     err_idle_reg,   // access to idle bank outside pattern mode, pulse
	output reg                     err_act_reg,    // activate to open/precharging bank
	output reg                     err_ovf_reg     // read queue overflow, pulse
);
	localparam ST_IDLE  = 1'b0;
	localparam ST_BURST = 1'b1;
	localparam PAT_W    = 8;

	// two-flop synchronisers for the ck, command, bank and address pins
	reg [4:0]             pin_s1_reg;
	reg [4:0]             pin_s2_reg;
	reg                   ck_prev_reg;
	reg [`DBR_BA_W-1:0]   ba_s1_reg;
	reg [`DBR_BA_W-1:0]   ba_s2_reg;
	reg [`DBR_ADDR_W-1:0] a_s1_reg;
	reg [`DBR_ADDR_W-1:0] a_s2_reg;
	always @(posedge clk_sys) begin
		if (!nrst) begin
			pin_s1_reg  <= 5'h1F;
			pin_s2_reg  <= 5'h1F;
			ck_prev_reg <= 1'b1;
			ba_s1_reg   <= 3'h0;
			ba_s2_reg   <= 3'h0;
			a_s1_reg    <= 15'h0000;
			a_s2_reg    <= 15'h0000;
		end else begin
			pin_s1_reg  <= {ck, cs_n, ras_n, cas_n, we_n};
			pin_s2_reg  <= pin_s1_reg;
			ck_prev_reg <= pin_s2_reg[4];
			ba_s1_reg   <= bank_select;
			ba_s2_reg   <= ba_s1_reg;
			a_s1_reg    <= addr;
			a_s2_reg    <= a_s1_reg;
		end
	end

	wire ck_rise;
	wire ck_edge;
	wire cmd_act;
	wire cmd_pre;
	wire cmd_rd;
	wire cmd_wr;
	wire cmd_mrs;
	wire [2:0] ba;
	assign ck_rise = pin_s2_reg[4] && !ck_prev_reg;
	assign ck_edge = pin_s2_reg[4] != ck_prev_reg;
	assign ba      = ba_s2_reg;
	assign cmd_act = ck_rise && (pin_s2_reg[3:0] == 4'h3);
	assign cmd_pre = ck_rise && (pin_s2_reg[3:0] == 4'h2);
	assign cmd_rd  = ck_rise && (pin_s2_reg[3:0] == 4'h5);
	assign cmd_wr  = ck_rise && (pin_s2_reg[3:0] == 4'h4);
	assign cmd_mrs = ck_rise && (pin_s2_reg[3:0] == 4'h0);

	// per-bank row state and precharge timer
	reg  [`DBR_ADDR_W-1:0] row_reg [0:`DBR_NBANK-1];
	wire [`DBR_NBANK-1:0]  pre_busy;
	genvar gi;
	generate
		for (gi = 0; gi < `DBR_NBANK; gi = gi + 1) begin : g_bank
			reg [`DBR_PRE_W-1:0] tmr_reg;
			wire hit;
			wire close;
			assign hit   = (ba == gi);
			assign close = (cmd_pre && (a_s2_reg[`DBR_A_AUTOPRE] || hit)) ||
			               ((cmd_rd || cmd_wr) && hit && bank_open_reg[gi] &&
			                a_s2_reg[`DBR_A_AUTOPRE]);
			assign pre_busy[gi] = (tmr_reg != 5'h00);
			always @(posedge clk_sys) begin
				if (!nrst) begin
					bank_open_reg[gi] <= 1'b0;
					row_reg[gi]       <= 15'h0000;
					tmr_reg           <= 5'h00;
				end else if (cmd_act && hit) begin
					bank_open_reg[gi] <= 1'b1; // RQ4
					row_reg[gi]       <= a_s2_reg; // RQ4
				end else if (close) begin // RQ5
					bank_open_reg[gi] <= 1'b0; // RQ7
					// activate is legal on the rise that ends the period, hence one less
					tmr_reg           <= `DBR_PRE_CK - 5'h01; // RQ11
				end else if (ck_rise && pre_busy[gi]) begin
					tmr_reg <= tmr_reg - 5'h01;
				end
			end
		end
	endgenerate

	// mode register three
	reg [1:0] pat_sel_reg;
	always @(posedge clk_sys) begin
		if (!nrst) begin
			pattern_en_reg <= 1'b0;
			pat_sel_reg    <= 2'h0;
		end else if (cmd_mrs && ba == `DBR_MR3_BA) begin
			pattern_en_reg <= a_s2_reg[`DBR_MR3_EN];
			pat_sel_reg    <= a_s2_reg[`DBR_MR3_SELHI:0];
		end
	end

	// error flags
	wire open_ba;
	assign open_ba = bank_open_reg[ba];
	always @(posedge clk_sys) begin
		if (!nrst) begin
			err_idle_reg <= 1'b0;
			err_act_reg  <= 1'b0;
		end else begin
			err_idle_reg <= (cmd_rd || cmd_wr) && !open_ba && !pattern_en_reg; // RQ19
			err_act_reg  <= cmd_act && (open_ba || pre_busy[ba]); // RQ19
		end
	end

	// link clock cycle counter, used to time read latency
	reg [`DBR_TIME_W-1:0] ck_time_reg;
	always @(posedge clk_sys) begin
		if (!nrst)
			ck_time_reg <= 8'h00;
		else if (ck_rise)
			ck_time_reg <= ck_time_reg + 8'h01;
	end

	// read descriptor: due, bc4, upper nibble, pattern, sel, bank, row, column
	wire [`DBR_TIME_W-1:0] rl;
	wire [`DBR_DESC_W-1:0] desc_in;
	wire [`DBR_DESC_W-1:0] desc_out;
	wire                   q_in_ready;
	wire                   q_out_valid;
	wire                   q_pop;
	wire                   rd_ok;
	assign rl = {4'h0, additive_latency} + {4'h0, cas_latency}; // RQ15
	assign rd_ok = cmd_rd && (open_ba || pattern_en_reg); // RQ10
	assign desc_in = {ck_time_reg + rl, // RQ15
	                  !a_s2_reg[`DBR_A_BLSEL], // RQ12 RQ14
	                  a_s2_reg[`DBR_A_NIBBLE], // RQ2
	                  pattern_en_reg, // RQ16
	                  pat_sel_reg,
	                  ba,
	                  row_reg[ba],
	                  a_s2_reg[`DBR_COL_HI:`DBR_COL_LO]}; // RQ13

	always @(posedge clk_sys) begin
		if (!nrst)
			err_ovf_reg <= 1'b0;
		else
			err_ovf_reg <= rd_ok && !q_in_ready;
	end

	dbr_fifo #(
		.W  (`DBR_DESC_W),
		.D  (`DBR_FIFO_D),
		.AW (`DBR_FIFO_AW)
	) u_rdq (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.in_data   (desc_in),
		.in_valid  (rd_ok),
		.in_ready  (q_in_ready),
		.out_data  (desc_out),
		.out_valid (q_out_valid),
		.out_ready (q_pop)
	);

	// burst engine: one beat per link clock edge
	reg        state_reg;
	reg [3:0]  left_reg;
	reg [2:0]  pos_reg;
	reg        pat_reg;
	reg [1:0]  sel_reg;
	reg        emit_reg;
	wire       head_due;
	wire [2:0] start_pos;
	assign head_due  = q_out_valid && (desc_out[37:30] == ck_time_reg);
	assign q_pop     = ck_rise && (left_reg == 4'h0) && head_due;
	assign start_pos = desc_out[28] ? `DBR_NIB_BASE : 3'h0; // RQ2
	always @(posedge clk_sys) begin
		if (!nrst) begin
			state_reg      <= ST_IDLE;
			left_reg       <= 4'h0;
			pos_reg        <= 3'h0;
			pat_reg        <= 1'b0;
			sel_reg        <= 2'h0;
			emit_reg       <= 1'b0;
			array_bank_reg <= 3'h0;
			array_row_reg  <= 15'h0000;
			array_col_reg  <= 10'h000;
		end else begin
			emit_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (q_pop) begin
						state_reg      <= ST_BURST;
						left_reg       <= (desc_out[29] ? `DBR_BEATS_BC4 : // RQ12
						                   `DBR_BEATS_BL8) - 4'h1;
						pos_reg        <= start_pos;
						pat_reg        <= desc_out[27];
						sel_reg        <= desc_out[26:25];
						array_bank_reg <= desc_out[24:22];
						array_row_reg  <= desc_out[21:7];
						array_col_reg  <= {desc_out[6:0], start_pos};
						emit_reg       <= 1'b1;
					end
				end
				ST_BURST: begin
					if (ck_edge) begin
						if (left_reg != 4'h0) begin
							left_reg      <= left_reg - 4'h1;
							pos_reg       <= pos_reg + 3'h1;
							array_col_reg <= {array_col_reg[9:3], pos_reg + 3'h1};
							emit_reg      <= 1'b1;
						end else if (q_pop) begin
							left_reg       <= (desc_out[29] ? `DBR_BEATS_BC4 :
							                   `DBR_BEATS_BL8) - 4'h1;
							pos_reg        <= start_pos;
							pat_reg        <= desc_out[27];
							sel_reg        <= desc_out[26:25];
							array_bank_reg <= desc_out[24:22];
							array_row_reg  <= desc_out[21:7];
							array_col_reg  <= {desc_out[6:0], start_pos};
							emit_reg       <= 1'b1;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// beat data: pattern bit on every lane, or the array word
	wire [PAT_W-1:0] pattern;
	wire             pat_bit;
	assign pattern = `DBR_PATTERN;
	assign pat_bit = (sel_reg == `DBR_SEL_PAT) ? pattern[pos_reg] : 1'b0; // RQ1 RQ3
	always @(posedge clk_sys) begin
		if (!nrst) begin
			dq_out_reg   <= 16'h0000;
			dq_valid_reg <= 1'b0;
			beat_pos_reg <= 3'h0;
		end else begin
			dq_valid_reg <= emit_reg;
			if (emit_reg) begin
				dq_out_reg   <= pat_reg ? {`DBR_DQ_W{pat_bit}} : array_data; // RQ1 RQ16
				beat_pos_reg <= pos_reg;
			end
		end
	end
endmodule

// File: dbr_pad.v
`timescale 1ns/100ps

// File: dbr_checker.sv
`timescale 1ns/100ps
module dbr_checker (
	input wire logic        clk_sys,        // system clock
	input wire logic        nrst,           // sync reset
	input wire logic [15:0] dq_out_reg,     // beat data
	input wire logic        dq_valid_reg,   // beat strobe
	input wire logic [2:0]  beat_pos_reg,   // beat position
	input wire logic [7:0]  bank_open_reg,  // open banks
	input wire logic        pattern_en_reg, // pattern mode
	input wire logic        err_idle_reg,   // idle access
	input wire logic        err_act_reg     // bad activate
);
	localparam logic [7:0] PAT = 8'hAA;
	logic [2:0] pos_q;
	logic [7:0] gap;
	// gap counts clocks since the last beat, saturating
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pos_q <= 3'h0;
			gap   <= 8'hFF;
		end else if (dq_valid_reg) begin
			pos_q <= beat_pos_reg;
			gap   <= 8'h00;
		end else if (gap != 8'hFF) begin
			gap <= gap + 8'h01;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	AST_RESET_QUIET: assert property ($rose(nrst) |->
		bank_open_reg == 8'h00 && !dq_valid_reg && !pattern_en_reg)
		else $error("outputs not clear after reset");
	AST_VALID_PULSE: assert property (dq_valid_reg |=> !dq_valid_reg)
		else $error("beat strobe longer than one cycle");
	AST_IDLE_PULSE: assert property (err_idle_reg |=> !err_idle_reg)
		else $error("idle access flag not a pulse");
	AST_ACT_PULSE: assert property (err_act_reg |=> !err_act_reg)
		else $error("activate flag not a pulse");
	AST_ACT_OPENS: assert property (err_act_reg |-> ##[0:2] bank_open_reg != 8'h00)
		else $error("refused activate left no bank open");
	AST_PAT_DATA: assert property (dq_valid_reg && pattern_en_reg |->
		dq_out_reg == {16{PAT[beat_pos_reg]}} || dq_out_reg == 16'h0000)
		else $error("pattern beat data wrong");
	AST_BEAT_ORDER: assert property (dq_valid_reg && gap < 8'h08 |->
		beat_pos_reg == pos_q + 3'h1 || (pos_q == 3'h7 && beat_pos_reg == 3'h4))
		else $error("beat order broken");
	AST_NIBBLE_START: assert property (dq_valid_reg && gap > 8'h10 |->
		beat_pos_reg == 3'h0 || beat_pos_reg == 3'h4)
		else $error("burst starts mid nibble");
endmodule

// File: dbr_ctl_model.sv
`timescale 1ns/100ps
module dbr_ctl_model (
	output logic        ck,    // free running link clock
	output logic        cs_n,  // chip select
	output logic        ras_n, // row strobe
	output logic        cas_n, // column strobe
	output logic        we_n,  // write enable
	output logic [2:0]  ba,    // bank select
	output logic [14:0] addr   // address
);
	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		ba = 3'h0;
		addr = 15'h0000;
		ck = 1'b0;
		forever #24 ck = ~ck;
	end
	// command, bank and address held across one link clock rise, then bank and address inverted
	task cmd(input [3:0] c, input [2:0] b, input [14:0] a, output realtime t);
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= a;
		@(posedge ck);
		t = $realtime;
		@(negedge ck);
		{cs_n, ras_n, cas_n, we_n} <= 4'hF;
		ba <= ~b;
		addr <= ~a;
	endtask
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        clk_sys, nrst, ck, cs_n, ras_n, cas_n, we_n, dq_valid, pat_en;
	logic        e_idle, e_act, e_ovf;
	logic [2:0]  ba, a_bank, pos;
	logic [14:0] addr, a_row;
	logic [9:0]  a_col;
	logic [15:0] dq, a_data;
	logic [7:0]  b_open;
	logic [3:0]  al, cl;
	logic [14:0] rows [8];
	int          n_errors, samples_checked, idle_cnt, act_cnt, ovf_cnt;
	assign a_data = {a_bank, a_row[5:0], a_col[6:0]};
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		idle_cnt <= idle_cnt + e_idle;
		act_cnt <= act_cnt + e_act;
		ovf_cnt <= ovf_cnt + e_ovf;
	end
	dbr_ctl_model ctl (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.ba(ba), .addr(addr));
	dbr_core uut (.clk_sys(clk_sys), .nrst(nrst), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_select(ba), .addr(addr), .additive_latency(al),
		.cas_latency(cl), .array_data(a_data), .array_bank_reg(a_bank), .array_row_reg(a_row),
		.array_col_reg(a_col), .dq_out_reg(dq), .dq_valid_reg(dq_valid), .beat_pos_reg(pos),
		.bank_open_reg(b_open), .pattern_en_reg(pat_en), .err_idle_reg(e_idle),
		.err_act_reg(e_act), .err_ovf_reg(e_ovf));
	task chk(input [15:0] got, input [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task op(input [3:0] c, input [2:0] b, input [14:0] a);
		realtime t;
		ctl.cmd(c, b, a, t);
		repeat (4) @(negedge clk_sys);
	endtask
	// one read burst, each beat judged against pattern or array word
	task rd(input [2:0] b, input [14:0] a, input pat);
		realtime t0;
		int n;
		logic [2:0] p;
		n = a[12] ? 8 : 4;
		p = a[12] ? 3'h0 : {a[2], 2'h0};
		ctl.cmd(4'h5, b, a, t0);
		for (int i = 0; i < 400 && n > 0; i++) begin
			@(negedge clk_sys);
			if (dq_valid === 1'b1) begin
				if (n == (a[12] ? 8 : 4))
					chk({15'h0, $realtime - t0 >= 432 && $realtime - t0 < 472}, 16'h1);
				chk(dq, pat ? {16{p[0]}} : {b, rows[b][5:0], a[6:3], p});
				chk({13'h0, pos}, {13'h0, p});
				p++;
				n--;
			end
		end
		if (n > 0) begin
			n_errors++;
			final_report;
		end
	endtask
	task t_pattern;
		int i0;
		i0 = idle_cnt;
		op(4'h0, 3'h3, 15'h0004);
		chk({15'h0, pat_en}, 16'h0001);
		rd(3'h0, 15'h1000, 1'b1);
		rd(3'h5, 15'h0000, 1'b1);
		rd(3'h7, 15'h0404, 1'b1);
		chk(16'(idle_cnt - i0), 16'h0000);
	endtask
	task t_array;
		int i0, a0;
		op(4'h0, 3'h3, 15'h0000);
		chk({15'h0, pat_en}, 16'h0000);
		i0 = idle_cnt;
		op(4'h5, 3'h2, 15'h0048);
		chk(16'(idle_cnt - i0), 16'h0001);
		op(4'h4, 3'h2, 15'h0048);
		chk(16'(idle_cnt - i0), 16'h0002);
		rows[2] = 15'h1234;
		rows[6] = 15'h0021;
		op(4'h3, 3'h2, rows[2]);
		op(4'h3, 3'h6, rows[6]);
		chk({8'h0, b_open}, 16'h0044);
		rd(3'h2, 15'h1048, 1'b0);
		rd(3'h2, 15'h0048, 1'b0);
		a0 = act_cnt;
		op(4'h3, 3'h6, rows[6]);
		chk(16'(act_cnt - a0), 16'h0001);
		rd(3'h2, 15'h1448, 1'b0);
		rd(3'h6, 15'h1050, 1'b0);
		chk({8'h0, b_open}, 16'h0040);
		op(4'h2, 3'h6, 15'h0400);
		chk({8'h0, b_open}, 16'h0000);
		op(4'h3, 3'h6, rows[6]);
		chk(16'(act_cnt - a0), 16'h0002);
		op(4'h2, 3'h6, 15'h0000);
		repeat (12) @(posedge ck);
		op(4'h3, 3'h2, rows[2]);
		chk(16'(act_cnt - a0), 16'h0002);
		chk({8'h0, b_open}, 16'h0004);
		// activate one rise before the period ends is flagged, on its last rise it is not
		op(4'h2, 3'h2, 15'h0000);
		repeat (9) @(posedge ck);
		op(4'h3, 3'h2, rows[2]);
		chk(16'(act_cnt - a0), 16'h0003);
		op(4'h2, 3'h2, 15'h0000);
		repeat (10) @(posedge ck);
		op(4'h3, 3'h2, rows[2]);
		chk(16'(act_cnt - a0), 16'h0003);
		// a second precharge restarts the period
		op(4'h2, 3'h2, 15'h0000);
		repeat (4) @(posedge ck);
		op(4'h2, 3'h2, 15'h0000);
		repeat (5) @(posedge ck);
		op(4'h3, 3'h2, rows[2]);
		chk(16'(act_cnt - a0), 16'h0004);
	endtask
	// reads two link cycles apart with long latency fill the queue, then reset mid-run
	task t_overflow;
		realtime t;
		int o0;
		o0 = ovf_cnt;
		@(posedge clk_sys);
		al <= 4'hF;
		cl <= 4'hF;
		for (int i = 0; i < 18; i++)
			ctl.cmd(4'h5, 3'h2, 15'h1048, t);
		repeat (4) @(negedge clk_sys);
		chk(16'(ovf_cnt - o0), 16'h0001);
		@(posedge clk_sys);
		nrst <= 1'b0;
		al <= 4'h4;
		cl <= 4'h5;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(negedge clk_sys);
		chk({8'h0, b_open}, 16'h0000);
		chk({15'h0, pat_en}, 16'h0000);
		op(4'h3, 3'h2, rows[2]);
		chk({8'h0, b_open}, 16'h0004);
		rd(3'h2, 15'h1048, 1'b0);
	endtask
	initial begin
		nrst = 1'b0;
		al = 4'h4;
		cl = 4'h5;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_pattern;
		t_array;
		t_overflow;
		final_report;
	end
endmodule
bind dbr_core dbr_checker chk_i (.clk_sys(clk_sys), .nrst(nrst), .dq_out_reg(dq_out_reg),
	.dq_valid_reg(dq_valid_reg), .beat_pos_reg(beat_pos_reg), .bank_open_reg(bank_open_reg),
	.pattern_en_reg(pattern_en_reg), .err_idle_reg(err_idle_reg), .err_act_reg(err_act_reg));
